// [rmc_cfg.svh]
// offsets, field positions, reset values and timing counts for mode control
// assumes inclusion by bare name from the pattern store and the mode decoder only
`ifndef RMC_CFG_SVH
`define RMC_CFG_SVH

// register offsets on the plain register port
`define RMC_PD_ADDR      8'h02
`define RMC_STAT_ADDR    8'h03

// power-down control register fields
`define RMC_PD_PULSE     0
`define RMC_PD_SERVO     1
`define RMC_PD_FILTER    2
`define RMC_PD_SEP       3
`define RMC_PD_SYNTH     4
`define RMC_PD_FIXED     3'h7
`define RMC_PD_RESET     5'h00

// read sequence timing, in 3T periods and clock cycles per 3T
`define RMC_T3_CYCLES    3
`define RMC_SETTLE_3T    3
`define RMC_LOCK_3T      19

// write side address mark and preamble, sent msb first
`define RMC_MARK_BITS    40'h0101001001
`define RMC_PRE_BITS     9'h124
`define RMC_PAT_LEN      89

`endif

// [rmc_ctrl_model.sv]
// controller model: drives the gates, the sleep pin and write bits
// assumes requests from the bench on the same rising clock edge
`default_nettype none

module rmc_ctrl_model (
  // clock
  input  wire logic       i_clk,
  // requested mode: 0 sleep, 1 idle, 2 read, 3 write, 4 servo
  input  wire logic [2:0] i_req,
  // write data path
  input  wire logic       i_data,
  input  wire logic       i_bits_en,
  // pins toward the device
  output logic            o_write_gate,
  output logic            o_read_gate,
  output logic            o_servo_gate,
  output logic            o_sleep_n,
  output logic            o_write_bits
);
  logic [2:0] eff;
  logic [2:0] wake_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // a write straight out of sleep is illegal, so idle a few cycles first;
  // the device must see the write gate low after it has left sleep
  always_ff @(posedge i_clk) begin
    if (eff == 3'h0) begin
      wake_cnt <= 3'h0;
    end else if (wake_cnt != 3'h7) begin
      wake_cnt <= wake_cnt + 3'h1;
    end
  end

  always_comb begin
    eff = i_req;
    if (i_req == 3'h3 && wake_cnt < 3'h4) begin
      eff = 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    o_sleep_n    <= (eff != 3'h0);
    o_write_gate <= (eff == 3'h3);
    o_read_gate  <= (eff == 3'h2);
    o_servo_gate <= (eff != 3'h4);
  end

  // data held at zero until the device takes it
  always_ff @(posedge i_clk) begin
    o_write_bits <= i_bits_en ? i_data : 1'b0;
  end
endmodule : rmc_ctrl_model

`default_nettype wire

// [rmc_mark_gen.sv]
// pattern store: two address marks then preamble, one bit per clock
// assumes start and abort come from logic on the same clock
`include "rmc_cfg.svh"
`default_nettype none

module rmc_mark_gen
  import rmc_pkg::*;
#(
  parameter int LEN = `RMC_PAT_LEN
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_start,
  input  wire logic i_abort,
  // serial pattern
  output logic      o_bit,
  output logic      o_valid,
  output logic      o_done
);

  localparam int IW = $clog2(LEN + 1);
  localparam logic [LEN-1:0] PAT =
    {`RMC_MARK_BITS, `RMC_MARK_BITS, `RMC_PRE_BITS};

  logic [IW-1:0] idx;

  if (LEN != 2 * 40 + 9) begin : g_len_chk
    $error("pattern length must match marks plus preamble");
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_abort) begin
      idx     <= '0;
      o_bit   <= 1'b0;
      o_valid <= 1'b0;
      o_done  <= 1'b0;
    end else if (i_start) begin
      idx     <= IW'(1);
      o_bit   <= PAT[LEN-1];
      o_valid <= 1'b1;
      o_done  <= 1'b0;
    end else if (o_valid) begin
      if (idx == IW'(LEN)) begin
        o_valid <= 1'b0;
        o_done  <= 1'b1;
        o_bit   <= 1'b0;
      end else begin
        o_bit <= PAT[IW'(LEN - 1) - idx];
        idx   <= idx + IW'(1);
      end
    end
  end

endmodule : rmc_mark_gen

`default_nettype wire

// [rmc_mode_ctrl.sv]
// read channel mode decoder and read/write sequencer
// assumes gate, sleep and detector levels arrive from outside the clock
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`include "rmc_cfg.svh"
`default_nettype none

module rmc_mode_ctrl
  import rmc_pkg::*;
#(
  parameter int T3_CYCLES = `RMC_T3_CYCLES,
  parameter int CNT_W     = 8
) (
  // clock and reset
  input  wire logic      I_CLK,
  input  wire logic      I_RST_N,
  // register port
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic      I_WR,
  input  wire logic      I_RD,
  output logic     [7:0] O_RDATA,
  // controller gates and sleep pin
  input  wire logic      I_WRITE_GATE,
  input  wire logic      I_READ_GATE,
  input  wire logic      I_SERVO_GATE,
  input  wire logic      I_GLOBAL_SLEEP_N,
  // detector and data inputs
  input  wire logic      I_MARK_DETECT,
  input  wire logic      I_PULSE_DET,
  input  wire logic      I_SEP_BITS,
  input  wire logic      I_WRITE_BITS,
  // block power and clock steering
  output rmc_power_type  O_POWER,
  output rmc_mode_type   O_MODE,
  output rmc_pll_ref_type O_PLL_REF,
  output logic           O_RECOV_FROM_VCO,
  output logic           O_MARK_SEARCH,
  // pins toward the controller
  output rmc_pin_type    O_READ_BITS,
  output rmc_pin_type    O_MARK_FOUND,
  output rmc_pin_type    O_PULSE_IO,
  output logic           O_ENCODED_WRITE,
  output logic           O_WRITE_BITS_EN,
  // front end control
  output logic           O_GAIN_HOLD_EN,
  output logic           O_INPUT_SHORT,
  output logic           O_FAST_ACQ
);

  localparam int SETTLE_N = `RMC_SETTLE_3T * T3_CYCLES;
  localparam int LOCK_N   = `RMC_LOCK_3T * T3_CYCLES;

  if (T3_CYCLES < 1 || LOCK_N >= 2 ** CNT_W) begin : g_par_chk
    $error("3T cycle count does not fit the sequence counter");
  end

  function automatic logic is_read(input rmc_mode_type s);
    is_read = (s == ST_SEARCH) || (s == ST_SETTLE) ||
              (s == ST_LOCK) || (s == ST_READ);
  endfunction : is_read

  rmc_gates_type    gates_meta;
  rmc_gates_type    g;
  rmc_mode_type     st;
  rmc_mode_type     next_st;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [4:0]       pd;
  logic             wr_block;
  logic             was_write;
  logic             mark_hit;
  logic             next_mark_hit;
  logic             gen_bit;
  logic             gen_valid;
  logic             gen_done;
  logic             awake;
  logic             fe_on;

  //////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser; only the second stage feeds decode
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      gates_meta <= '0;
      g          <= '0;
    end else begin
      gates_meta <= '{I_WRITE_GATE, I_READ_GATE, I_SERVO_GATE,
                      I_GLOBAL_SLEEP_N, I_MARK_DETECT, I_PULSE_DET};
      g          <= gates_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register port; unmapped reads return zero
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      pd <= `RMC_PD_RESET;
    end else if (I_WR && I_ADDR == `RMC_PD_ADDR) begin
      pd <= I_WDATA[4:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_RDATA <= 8'h00;
    end else if (I_RD && I_ADDR == `RMC_PD_ADDR) begin
      O_RDATA <= {`RMC_PD_FIXED, pd};
    end else if (I_RD && I_ADDR == `RMC_STAT_ADDR) begin
      O_RDATA <= st;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write needs the gate seen low after sleep, so a held gate cannot
  // slip straight into write on wake-up
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      wr_block <= 1'b1;
    end else if (st == ST_SLEEP) begin
      wr_block <= 1'b1;
    end else if (!g.write) begin
      wr_block <= 1'b0;
    end
  end

  // mode decode from synchronised levels
  always_comb begin
    next_st  = st;
    next_cnt = '0;
    if (!g.sleep_n) begin
      next_st = ST_SLEEP;
    end else if (g.write && !g.read && g.servo) begin
      next_st = wr_block ? ST_IDLE : ST_WRITE;
    end else if (!g.write && !g.servo) begin
      next_st = ST_SERVO;
    end else if (!g.write && g.read && g.servo) begin
      case (st)
        ST_SEARCH: begin
          if (g.mark) begin
            next_st = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (cnt == CNT_W'(SETTLE_N - 1)) begin
            next_st = ST_LOCK;
          end else begin
            next_cnt = cnt + CNT_W'(1);
          end
        end
        ST_LOCK: begin
          if (cnt == CNT_W'(LOCK_N - 1)) begin
            next_st = ST_READ;
          end else begin
            next_cnt = cnt + CNT_W'(1);
          end
        end
        ST_READ: begin
          next_st = ST_READ;
        end
        default: begin
          next_st = ST_SEARCH;
        end
      endcase
    end else begin
      next_st = ST_IDLE;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st  <= ST_SLEEP;
      cnt <= '0;
    end else begin
      st  <= next_st;
      cnt <= next_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mark latch, cleared whenever a new search opens
  always_comb begin
    next_mark_hit = mark_hit;
    if (next_st == ST_SEARCH || !is_read(next_st)) begin
      next_mark_hit = 1'b0;
    end else if (st == ST_SEARCH && g.mark) begin
      next_mark_hit = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      mark_hit  <= 1'b0;
      was_write <= 1'b0;
    end else begin
      mark_hit  <= next_mark_hit;
      was_write <= (st == ST_WRITE);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write preamble source; aborted as soon as write mode ends
  rmc_mark_gen #(
    .LEN (`RMC_PAT_LEN)
  ) u_mark_gen (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_start (st == ST_WRITE && !was_write),
    .i_abort (st != ST_WRITE),
    .o_bit   (gen_bit),
    .o_valid (gen_valid),
    .o_done  (gen_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // outputs registered from the next state so they line up with st
  assign awake = (next_st != ST_SLEEP);
  assign fe_on = awake && (next_st != ST_WRITE);

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_POWER <= '0;
    end else begin
      O_POWER.front_end   <= fe_on;
      O_POWER.pulse_det   <= fe_on && !pd[`RMC_PD_PULSE];
      O_POWER.filter      <= fe_on && !pd[`RMC_PD_FILTER];
      O_POWER.servo_demod <= awake && !pd[`RMC_PD_SERVO];
      O_POWER.separator   <= awake && !pd[`RMC_PD_SEP];
      O_POWER.synth       <= awake && !pd[`RMC_PD_SYNTH];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_MODE           <= ST_SLEEP;
      O_PLL_REF        <= REF_FOUT;
      O_RECOV_FROM_VCO <= 1'b0;
      O_MARK_SEARCH    <= 1'b0;
    end else begin
      O_MODE           <= next_st;
      O_MARK_SEARCH    <= (next_st == ST_SEARCH);
      O_RECOV_FROM_VCO <= (next_st == ST_READ);
      if (next_st == ST_SEARCH || next_st == ST_SETTLE) begin
        O_PLL_REF <= REF_HALF;
      end else if (next_st == ST_LOCK || next_st == ST_READ) begin
        O_PLL_REF <= REF_PULSES;
      end else if (next_st == ST_WRITE) begin
        O_PLL_REF <= REF_DIV30;
      end else begin
        O_PLL_REF <= REF_FOUT;
      end
    end
  end

  // pin drive per mode; floated pins carry zero
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_READ_BITS  <= '0;
      O_MARK_FOUND <= '0;
      O_PULSE_IO   <= '0;
    end else begin
      O_READ_BITS.oe <= (next_st == ST_READ);
      O_READ_BITS.o  <= (next_st == ST_READ) && I_SEP_BITS;
      if (is_read(next_st)) begin
        O_MARK_FOUND <= '{next_mark_hit, 1'b1};
      end else if (next_st == ST_IDLE || next_st == ST_SERVO) begin
        O_MARK_FOUND <= '{1'b1, 1'b1};
      end else begin
        O_MARK_FOUND <= '0;
      end
      // read mode keeps the pulse pin quiet
      O_PULSE_IO.oe <= (next_st == ST_IDLE) || (next_st == ST_SERVO);
      O_PULSE_IO.o  <= ((next_st == ST_IDLE) || (next_st == ST_SERVO))
                       && g.pulse;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_GAIN_HOLD_EN <= 1'b0;
      O_INPUT_SHORT  <= 1'b0;
      O_FAST_ACQ     <= 1'b0;
    end else begin
      // servo ignores the hold input
      O_GAIN_HOLD_EN <= is_read(next_st) || next_st == ST_IDLE;
      O_INPUT_SHORT  <= (next_st == ST_WRITE);
      O_FAST_ACQ     <= (st == ST_WRITE) && (next_st != ST_WRITE);
    end
  end

  // write bits accepted only after the pattern; the controller is
  // expected to hold them at zero until then
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_WRITE_BITS_EN <= 1'b0;
      O_ENCODED_WRITE <= 1'b0;
    end else begin
      O_WRITE_BITS_EN <= (st == ST_WRITE) && gen_done;
      if (gen_valid) begin
        O_ENCODED_WRITE <= gen_bit;
      end else begin
        O_ENCODED_WRITE <= O_WRITE_BITS_EN && I_WRITE_BITS;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertion helpers: cycles spent in settle and lock
  logic [CNT_W-1:0] settle_age;
  logic [CNT_W-1:0] lock_age;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      settle_age <= '0;
      lock_age   <= '0;
    end else begin
      settle_age <= (st == ST_SETTLE) ? settle_age + CNT_W'(1) : '0;
      lock_age   <= (st == ST_LOCK) ? lock_age + CNT_W'(1) : '0;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  a_sleep_power_off: assert property (
    !g.sleep_n |=> (O_MODE == ST_SLEEP) && (O_POWER == '0)
  ) else $error("sleep pin low did not power down");

  a_no_wake_write: assert property (
    (st == ST_SLEEP) |=> (st != ST_WRITE) [*2]
  ) else $error("write entered straight from sleep");

  a_read_front_end: assert property (
    is_read(st) |-> O_POWER.front_end && !O_PULSE_IO.oe && O_GAIN_HOLD_EN
  ) else $error("read mode front end or pins wrong");

  a_search_waits: assert property (
    (st == ST_SEARCH) && !g.mark |=> (st != ST_SETTLE)
  ) else $error("lock sequence began without a mark");

  a_settle_delay: assert property (
    $rose(st == ST_LOCK) |-> ($past(settle_age) == CNT_W'(SETTLE_N - 1))
      && (O_PLL_REF == REF_PULSES)
  ) else $error("reference switch not three 3T after mark");

  a_lock_delay: assert property (
    $rose(st == ST_READ) |-> ($past(lock_age) == CNT_W'(LOCK_N - 1))
      && O_RECOV_FROM_VCO && O_READ_BITS.oe
  ) else $error("clock handover not nineteen 3T after switch");

  a_read_holds: assert property (
    is_read(st) && g.sleep_n && g.read && g.servo && !g.write
      |=> is_read(st)
  ) else $error("read mode left while read gate high");

  a_write_pins: assert property (
    (st == ST_WRITE) |-> !O_READ_BITS.oe && !O_MARK_FOUND.oe
      && O_INPUT_SHORT && !O_POWER.front_end
  ) else $error("write mode pins or front end wrong");

  a_write_ref: assert property (
    (st == ST_WRITE) |-> (O_PLL_REF == REF_DIV30)
  ) else $error("write mode reference not divided by thirty");

  a_mark_pattern: assert property (
    disable iff (!I_RST_N || st != ST_WRITE)
    $rose(st == ST_WRITE) |-> ##2 (!O_ENCODED_WRITE) [*7]
      ##1 O_ENCODED_WRITE ##1 (!O_ENCODED_WRITE) [*7] ##1 O_ENCODED_WRITE
  ) else $error("address mark bits wrong");

  a_bits_gated: assert property (
    gen_valid |-> !O_WRITE_BITS_EN
  ) else $error("write bits accepted during pattern");

  a_write_exit: assert property (
    $fell(st == ST_WRITE) |-> O_FAST_ACQ && !O_INPUT_SHORT
  ) else $error("write exit without fast acquisition");

  a_idle_pins: assert property (
    (st == ST_IDLE) |-> (O_PLL_REF == REF_FOUT) && !O_RECOV_FROM_VCO
      && O_MARK_FOUND.o && O_MARK_FOUND.oe && !O_READ_BITS.oe
      && O_PULSE_IO.oe && O_GAIN_HOLD_EN && !O_INPUT_SHORT
  ) else $error("idle mode pins wrong");

  a_servo_pins: assert property (
    (st == ST_SERVO) |-> !O_GAIN_HOLD_EN && O_PULSE_IO.oe
      && (O_PLL_REF == REF_FOUT)
  ) else $error("servo mode pins wrong");

  a_servo_two: assert property (
    (st == ST_SERVO) && $stable(pd) |-> (O_POWER.synth == !pd[`RMC_PD_SYNTH])
      && (O_POWER.separator == !pd[`RMC_PD_SEP])
      && (O_POWER.pulse_det == !pd[`RMC_PD_PULSE])
  ) else $error("awake power does not follow register");

  a_pd_readback: assert property (
    I_RD && (I_ADDR == `RMC_PD_ADDR) |=> (O_RDATA[7:5] == `RMC_PD_FIXED)
  ) else $error("power register top bits not fixed");

  c_read_done: cover property ($rose(st == ST_READ));
  c_write_done: cover property ((st == ST_WRITE) && $rose(O_WRITE_BITS_EN));
  c_servo: cover property ($rose(st == ST_SERVO));
  c_wake: cover property ($fell(st == ST_SLEEP));

endmodule : rmc_mode_ctrl

`default_nettype wire

// [rmc_mode_ctrl_bench.sv]
// self-checking bench for the mode control block
// assumes the controller model beside it and a 100 ns clock
`default_nettype none

module rmc_mode_ctrl_bench
  import rmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int T3 = 3;

  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [7:0]      addr = 8'h00;
  logic [7:0]      wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic            mark = 1'b0;
  logic            pdet = 1'b0;
  logic            sep = 1'b0;
  logic            wd = 1'b0;
  logic [2:0]      req = 3'h0;
  logic [7:0]      rdata;
  rmc_power_type   power;
  rmc_mode_type    mode;
  rmc_pll_ref_type pref;
  rmc_pin_type     rbits, mfound, pio;
  logic            wg, rg, sg, sl_n, wbits, vco, search, enc;
  logic            wben, ghold, short_in, fast, last;
  int              err_count = 0;
  int              n_compared = 0;
  int              n, f;
  logic [99:0]     cap;
  logic [88:0]     got;
  logic [7:0]      v;
  logic [2:0]      ph;

  rmc_ctrl_model i_ctrl (
    .i_clk(clk), .i_req(req), .i_data(wd), .i_bits_en(wben),
    .o_write_gate(wg), .o_read_gate(rg), .o_servo_gate(sg),
    .o_sleep_n(sl_n), .o_write_bits(wbits)
  );

  rmc_mode_ctrl #(.T3_CYCLES(T3), .CNT_W(8)) i_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_WRITE_GATE(wg),
    .I_READ_GATE(rg), .I_SERVO_GATE(sg), .I_GLOBAL_SLEEP_N(sl_n),
    .I_MARK_DETECT(mark), .I_PULSE_DET(pdet), .I_SEP_BITS(sep),
    .I_WRITE_BITS(wbits), .O_POWER(power), .O_MODE(mode),
    .O_PLL_REF(pref), .O_RECOV_FROM_VCO(vco), .O_MARK_SEARCH(search),
    .O_READ_BITS(rbits), .O_MARK_FOUND(mfound), .O_PULSE_IO(pio),
    .O_ENCODED_WRITE(enc), .O_WRITE_BITS_EN(wben),
    .O_GAIN_HOLD_EN(ghold), .O_INPUT_SHORT(short_in), .O_FAST_ACQ(fast)
  );

  always #50 clk = ~clk;

  always @(posedge clk) begin
    pdet <= 1'($urandom);
    sep  <= 1'($urandom);
    wd   <= 1'($urandom);
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic rmc_power_type exp_power(input logic fe,
                                              input logic [4:0] off);
    return {fe, ~off[0], ~off[1], ~off[2], ~off[3], ~off[4]};
  endfunction : exp_power

  // two marks of gaps 7,7,11,11 then three 3T groups, first bit at msb
  function automatic logic [88:0] exp_pattern();
    logic [88:0] p;
    int          k;
    int          gap[4] = '{7, 7, 11, 11};
    p = '0;
    k = 0;
    for (int m = 0; m < 8; m++) begin
      k += gap[m % 4];
      p[88 - k] = 1'b1;
      k++;
    end
    for (int m = 0; m < 3; m++) begin
      p[88 - k] = 1'b1;
      k += 3;
    end
    return p;
  endfunction : exp_pattern

  task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_bit(input logic g, input logic e);
    chk_val({7'h0, g}, {7'h0, e});
  endtask : chk_bit

  task automatic chk_pat(input logic [88:0] g, input logic [88:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_pat

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk_val(rdata, e);
  endtask : reg_rd

  task automatic set_req(input logic [2:0] r);
    @(posedge clk);
    req <= r;
  endtask : set_req

  // bounded: a stuck sequencer shows up as a mode mismatch
  task automatic wait_mode(input rmc_mode_type m);
    n = 0;
    while (mode !== m && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk_val(mode, m);
  endtask : wait_mode

  task automatic count_mode(input rmc_mode_type m);
    n = 0;
    while (mode === m && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask : count_mode

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // about fifty times the expected run length
  initial begin
    #2000000;
    err_count++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(44971));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_val(mode, ST_SLEEP);
    reg_rd(8'h02, 8'hE0);
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      reg_wr(8'h02, v);
      reg_rd(8'h02, {3'h7, v[4:0]});
      chk_val({2'h0, power}, 8'h00);
    end
    reg_wr(8'h02, 8'h00);
    reg_wr(8'h55, 8'hFF);
    reg_rd(8'h55, 8'h00);
    reg_rd(8'h02, 8'hE0);
    reg_rd(8'h03, 8'h01);
    $display("test registers done");
    set_req(3'h1);
    wait_mode(ST_IDLE);
    chk_val({2'h0, power}, 8'h3F);
    chk_val({4'h0, pref}, {4'h0, REF_FOUT});
    chk_val({6'h0, mfound}, 8'h03);
    chk_bit(rbits.oe, 1'b0);
    chk_bit(pio.oe, 1'b1);
    chk_bit(ghold, 1'b1);
    chk_bit(short_in, 1'b0);
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      reg_wr(8'h02, v);
      repeat (2) @(negedge clk);
      chk_val({2'h0, power}, {2'h0, exp_power(1'b1, v[4:0])});
    end
    reg_wr(8'h02, 8'h00);
    $display("test idle done");
    set_req(3'h2);
    wait_mode(ST_SEARCH);
    chk_bit(search, 1'b1);
    chk_val({4'h0, pref}, {4'h0, REF_HALF});
    chk_val({2'h0, power}, 8'h3F);
    chk_bit(pio.oe, 1'b0);
    chk_bit(ghold, 1'b1);
    repeat (20) @(negedge clk);
    chk_val(mode, ST_SEARCH);
    @(posedge clk);
    mark <= 1'b1;
    wait_mode(ST_SETTLE);
    chk_bit(mfound.o, 1'b1);
    @(posedge clk);
    mark <= 1'b0;
    count_mode(ST_SETTLE);
    chk_val(8'(n), 8'(3 * T3));
    chk_val({4'h0, pref}, {4'h0, REF_PULSES});
    chk_bit(vco, 1'b0);
    count_mode(ST_LOCK);
    chk_val(8'(n), 8'(19 * T3));
    chk_val(mode, ST_READ);
    chk_bit(vco, 1'b1);
    chk_bit(rbits.oe, 1'b1);
    last = sep;
    repeat (40) begin
      @(negedge clk);
      chk_bit(rbits.o, last);
      last = sep;
    end
    chk_val(mode, ST_READ);
    set_req(3'h1);
    wait_mode(ST_IDLE);
    $display("test read done");
    set_req(3'h3);
    wait_mode(ST_WRITE);
    chk_bit(power.front_end, 1'b0);
    chk_bit(short_in, 1'b1);
    chk_val({6'h0, rbits.oe, mfound.oe}, 8'h00);
    chk_val({4'h0, pref}, {4'h0, REF_DIV30});
    for (int i = 0; i < 100; i++) begin
      cap[i] = enc;
      @(negedge clk);
    end
    f = 0;
    while (f < 99 && cap[f] !== 1'b1) f++;
    for (int k = 0; k < 89; k++) got[88 - k] = cap[f - 7 + k];
    chk_pat(got, exp_pattern());
    chk_bit(wben, 1'b1);
    last = wbits;
    repeat (16) begin
      @(negedge clk);
      chk_bit(enc, last);
      last = wbits;
    end
    set_req(3'h1);
    count_mode(ST_WRITE);
    chk_bit(fast, 1'b1);
    chk_bit(short_in, 1'b0);
    @(negedge clk);
    chk_bit(fast, 1'b0);
    $display("test write done");
    set_req(3'h4);
    wait_mode(ST_SERVO);
    chk_bit(pio.oe, 1'b1);
    chk_bit(ghold, 1'b0);
    chk_val({4'h0, pref}, {4'h0, REF_FOUT});
    chk_val({2'h0, power}, 8'h3F);
    // pulse pin lags the detector by two sync stages and one register
    for (int i = 0; i < 12; i++) begin
      if (i > 2) chk_bit(pio.o, ph[2]);
      ph = {ph[1:0], pdet};
      @(negedge clk);
    end
    reg_wr(8'h02, 8'h18);
    repeat (2) @(negedge clk);
    chk_val({2'h0, power}, {2'h0, exp_power(1'b1, 5'h18)});
    chk_val(mode, ST_SERVO);
    $display("test servo done");
    set_req(3'h0);
    wait_mode(ST_SLEEP);
    chk_val({2'h0, power}, 8'h00);
    chk_val({5'h0, rbits.oe, mfound.oe, pio.oe}, 8'h00);
    reg_wr(8'h02, 8'h00);
    set_req(3'h3);
    wait_mode(ST_WRITE);
    set_req(3'h1);
    wait_mode(ST_IDLE);
    $display("test sleep done");
    wrap_up();
  end
endmodule : rmc_mode_ctrl_bench

`default_nettype wire

// [rmc_pkg.sv]
// types shared by the mode control block and its pattern store
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package rmc_pkg;

  typedef enum logic [7:0] {
    ST_SLEEP  = 8'h01,
    ST_IDLE   = 8'h02,
    ST_SEARCH = 8'h04,
    ST_SETTLE = 8'h08,
    ST_LOCK   = 8'h10,
    ST_READ   = 8'h20,
    ST_WRITE  = 8'h40,
    ST_SERVO  = 8'h80
  } rmc_mode_type;

  typedef enum logic [3:0] {
    REF_FOUT   = 4'h1,
    REF_HALF   = 4'h2,
    REF_PULSES = 4'h4,
    REF_DIV30  = 4'h8
  } rmc_pll_ref_type;

  typedef struct packed {
    logic front_end;
    logic pulse_det;
    logic servo_demod;
    logic filter;
    logic separator;
    logic synth;
  } rmc_power_type;

  typedef struct packed {
    logic o;
    logic oe;
  } rmc_pin_type;

  typedef struct packed {
    logic write;
    logic read;
    logic servo;
    logic sleep_n;
    logic mark;
    logic pulse;
  } rmc_gates_type;

endpackage : rmc_pkg

`default_nettype wire
